// ===== verilog/sdadc_scan_ctrl.sv
// Scan sequencer, correction, averaging and interrupts of the sigma-delta converter
//
// Behaviour
// - Scan converts enabled channels in ascending order from channel 0.
// - Each unit raises its own conversion-done request per result.
// - Each unit raises its own scan-done request when its scan finishes.
// - Error flag travels in the same result word as the value.
// - Result word holds 24-bit value, overflow, error and channel number.
// - Results get offset then gain correction from per-channel registers.
// - Channels 0..5 each have mode, control, oversampling, gain, offset registers.
// - Per-channel disconnection current select among four levels.
// - Event link trigger starts a scan as alternative to software.
// - Averages go to a separate average-result register.
// - Module stop halts the unit and withholds its converter clock.
// - Modes: continuous scan, single scan, one-shot conversion.
// - Per-channel conversion count up to 8032; zero counts as one conversion.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "sdadc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sdadc_scan_ctrl
  import sdadc_pkg::*;
#(
  parameter int NU = `SD_NUM_UNIT,
  parameter int NC = `SD_NUM_CH
)(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  input  wire logic [NU-1:0]         hw_trig_in,
  output logic      [NU-1:0]         conv_start_out,
  output chan_cfg_s [NU-1:0]         cfg_out,
  output logic      [NU-1:0]         clk_en_out,
  input  wire logic [NU-1:0]         sample_valid_in,
  input  wire sample_s [NU-1:0]      sample_in,
  output logic                       unit0_conv_done_irq_out,
  output logic                       unit1_conv_done_irq_out,
  output logic                       unit0_scan_done_irq_out,
  output logic                       unit1_scan_done_irq_out,
  output logic                       irq_out
);
  // Per-unit results gathered for the shared read port and irq line
  logic [31:0]   rd_u   [NU];
  logic [NU-1:0] irq_u;
  logic [NU-1:0] cd_q;
  logic [NU-1:0] sd_q;
  logic [31:0]   rd_any;

  // ----------------------------------------------------------------
  // Next enabled channel at or above a start index
  // ----------------------------------------------------------------
  function automatic logic [3:0] next_ch(input logic [NC-1:0] en, input logic [2:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < NC; i++)
    begin
      if (en[i] && (3'(i) >= from) && !r[3])
        r = {1'b1, 3'(i)};
    end
    return r;
  endfunction : next_ch

  // ----------------------------------------------------------------
  // One scan controller per converter unit
  // ----------------------------------------------------------------
  for (genvar u = 0; u < NU; u++)
  begin : g_unit
    localparam logic UID = 1'(u);
    logic [31:0]     mode_r [NC];
    logic [2:0]      ctl_r  [NC];
    logic [15:0]     osr_r  [NC];
    logic [15:0]     gain_r [NC];
    logic [23:0]     offs_r [NC];
    logic [3:0]      uctl_r;
    logic [31:0]     res_r;
    logic [23:0]     avg_r;
    logic [29:0]     acc_r;
    logic [6:0]      an_r;
    logic [1:0]      ist_r;
    logic [1:0]      imk_r;
    scan_state_e     st_r;
    logic [2:0]      cur_r;
    logic [12:0]     cnt_r;
    chan_cfg_s       cfg_r;
    logic            cd_r;
    logic            sd_r;
    logic            req_r;
    logic            sel;
    logic            is_unit;
    logic            is_ch;
    logic [2:0]      slot;
    logic [2:0]      fld;
    logic            go;
    logic            halt;
    logic            cd_ev;
    logic            sd_ev;
    logic            last;
    logic [3:0]      nc_first;
    logic [3:0]      nc_next;
    logic [NC-1:0]   en;
    logic [12:0]     tgt;
    scan_mode_e      smode;
    logic signed [24:0] diff;
    logic signed [41:0] prod;
    logic signed [41:0] shf;
    logic [23:0]     corr;
    logic            c_ovf;
    logic [6:0]      an_tgt;
    logic [29:0]     acc_sum;

    // Address decode
    assign sel     = (addr_in[7] == UID);
    assign slot    = addr_in[6:4];
    assign fld     = addr_in[2:0];
    assign is_unit = sel && (slot == `SD_UNIT_SLOT);
    assign is_ch   = sel && (slot < 3'(NC));
    assign smode   = scan_mode_e'(uctl_r[`SD_UC_MODE]);
    assign halt    = uctl_r[`SD_UC_STOP]
                   || (wr_in && is_unit && fld == `SD_F_STOP)
                   || (wr_in && is_unit && fld == `SD_F_UCTRL && wdata_in[`SD_UC_STOP]);

    // Software start or event link start
    assign go = (wr_in && is_unit && fld == `SD_F_START)
              || (hw_trig_in[u] && uctl_r[`SD_UC_HWTRIG]);

    // Enabled channel vector and scan positions
    for (genvar c = 0; c < NC; c++)
    begin : g_en
      assign en[c] = mode_r[c][`SD_MODE_EN];
    end
    assign nc_first = next_ch(en, 3'h0);
    assign nc_next  = next_ch(en, cur_r + 3'h1);

    // Conversion count of the current channel; zero acts as one
    assign tgt   = (mode_r[cur_r][`SD_MODE_CNT] == 13'h0) ? 13'h1
                 : (mode_r[cur_r][`SD_MODE_CNT] > `SD_MAX_CNT) ? `SD_MAX_CNT
                 : mode_r[cur_r][`SD_MODE_CNT];
    assign cd_ev = (st_r == ST_WAIT) && sample_valid_in[u] && !halt;
    assign last  = (cnt_r + 13'h1 >= tgt);
    assign sd_ev = cd_ev && last && (smode != SCAN_ONE) && !nc_next[3];

    // Offset then gain correction with saturation
    always_comb
    begin
      diff  = $signed({sample_in[u].data[23], sample_in[u].data})
            - $signed({offs_r[cur_r][23], offs_r[cur_r]});
      prod  = $signed({{17{diff[24]}}, diff}) * $signed({26'h0, gain_r[cur_r]});
      shf   = prod >>> `SD_GAIN_FRAC;
      c_ovf = 1'b0;
      corr  = shf[23:0];
      if (shf > $signed(42'h000007FFFFF))
      begin
        corr  = 24'h7FFFFF;
        c_ovf = 1'b1;
      end
      else if (shf < $signed(42'h3FFFF800000))
      begin
        corr  = 24'h800000;
        c_ovf = 1'b1;
      end
    end

    // Averaging block size: 8, 16, 32 or 64 results
    assign an_tgt  = 7'(7'h1 << (`SD_AVG_MIN_LOG2 + mode_r[cur_r][`SD_MODE_ASEL]));
    assign acc_sum = acc_r + {{6{corr[23]}}, corr};

    // Register writes: channel settings and unit control
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        for (int c = 0; c < NC; c++)
        begin
          mode_r[c] <= 32'h0;
          ctl_r[c]  <= 3'h0;
          osr_r[c]  <= `SD_OSR_RST;
          gain_r[c] <= `SD_GAIN_RST;
          offs_r[c] <= 24'h0;
        end
        uctl_r <= 4'h0;
        imk_r  <= 2'h0;
      end
      else if (wr_in && is_ch)
      begin
        case (fld)
          `SD_F_MODE: mode_r[slot] <= wdata_in & 32'h1FFF000F;
          `SD_F_CTRL: ctl_r[slot]  <= wdata_in[2:0];
          `SD_F_OSR:  osr_r[slot]  <= wdata_in[15:0];
          `SD_F_GAIN: gain_r[slot] <= wdata_in[15:0];
          `SD_F_OFFS: offs_r[slot] <= wdata_in[23:0];
          default: ;
        endcase
      end
      else if (wr_in && is_unit)
      begin
        case (fld)
          `SD_F_UCTRL: uctl_r <= wdata_in[3:0];
          `SD_F_IMASK: imk_r  <= wdata_in[1:0];
          default: ;
        endcase
      end
    end

    // Scan sequencer
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        st_r  <= ST_IDLE;
        cur_r <= 3'h0;
        cnt_r <= 13'h0;
      end
      else if (halt)
        st_r <= ST_IDLE;
      else
      begin
        case (st_r)
          ST_IDLE:
          begin
            if (go && nc_first[3])
            begin
              cur_r <= nc_first[2:0];
              cnt_r <= 13'h0;
              st_r  <= ST_REQ;
            end
          end
          ST_REQ: st_r <= ST_WAIT;
          ST_WAIT:
          begin
            if (cd_ev)
            begin
              cnt_r <= cnt_r + 13'h1;
              if (smode == SCAN_ONE)
                st_r <= ST_IDLE;
              else if (!last)
                st_r <= ST_REQ;
              else if (nc_next[3])
              begin
                cur_r <= nc_next[2:0];
                cnt_r <= 13'h0;
                st_r  <= ST_REQ;
              end
              else if (smode == SCAN_CONT && nc_first[3])
              begin
                cur_r <= nc_first[2:0];
                cnt_r <= 13'h0;
                st_r  <= ST_REQ;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end

    // Result word with value, flags and channel
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
        res_r <= 32'h0;
      else if (cd_ev)
      begin
        res_r                <= 32'h0;
        res_r[23:0]          <= corr;
        res_r[`SD_RES_OVF]   <= c_ovf | sample_in[u].ovf;
        res_r[`SD_RES_ERR]   <= sample_in[u].err;
        res_r[`SD_RES_CH]    <= cur_r;
      end
    end

    // Averaging into its own register
    always_ff @(posedge clk_in)
    begin
      if (rst_in || (st_r == ST_IDLE) || (cd_ev && last))
      begin
        acc_r <= 30'h0;
        an_r  <= 7'h0;
      end
      if (rst_in)
        avg_r <= 24'h0;
      else if (cd_ev && mode_r[cur_r][`SD_MODE_AVG])
      begin
        if (an_r + 7'h1 == an_tgt)
        begin
          avg_r <= 24'(acc_sum >>> (`SD_AVG_MIN_LOG2 + mode_r[cur_r][`SD_MODE_ASEL]));
          acc_r <= 30'h0;
          an_r  <= 7'h0;
        end
        else if (!last)
        begin
          acc_r <= acc_sum;
          an_r  <= an_r + 7'h1;
        end
      end
    end

    // Sticky events; a read clears, a new event wins
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
        ist_r <= 2'h0;
      else
        ist_r <= ((rd_in && is_unit && fld == `SD_F_ISTAT) ? 2'h0 : ist_r) | {sd_ev, cd_ev};
    end

    // Event pulses, conversion request and datapath settings; the request
    // leaves one cycle after the channel index so the settings stand with it
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        cd_r  <= 1'b0;
        sd_r  <= 1'b0;
        req_r <= 1'b0;
        cfg_r <= '0;
      end
      else
      begin
        cd_r           <= cd_ev;
        sd_r           <= sd_ev;
        req_r          <= (st_r == ST_REQ) && !halt;
        cfg_r.chan     <= cur_r;
        cfg_r.osr      <= osr_r[cur_r];
        cfg_r.disc_sel <= ctl_r[cur_r][1:0];
        cfg_r.disc_en  <= ctl_r[cur_r][2];
      end
    end

    // Read mux of this unit
    always_comb
    begin
      rd_u[u] = 32'h0;
      if (is_ch)
      begin
        case (fld)
          `SD_F_MODE: rd_u[u] = mode_r[slot];
          `SD_F_CTRL: rd_u[u] = {29'h0, ctl_r[slot]};
          `SD_F_OSR:  rd_u[u] = {16'h0, osr_r[slot]};
          `SD_F_GAIN: rd_u[u] = {16'h0, gain_r[slot]};
          `SD_F_OFFS: rd_u[u] = {8'h0, offs_r[slot]};
          default:    rd_u[u] = 32'h0;
        endcase
      end
      else if (is_unit)
      begin
        case (fld)
          `SD_F_UCTRL:  rd_u[u] = {28'h0, uctl_r};
          `SD_F_RESULT: rd_u[u] = res_r;
          `SD_F_AVG:    rd_u[u] = {8'h0, avg_r};
          `SD_F_STAT:   rd_u[u] = {26'h0, cur_r, st_r != ST_IDLE, st_r};
          `SD_F_ISTAT:  rd_u[u] = {30'h0, ist_r};
          `SD_F_IMASK:  rd_u[u] = {30'h0, imk_r};
          default:      rd_u[u] = 32'h0;
        endcase
      end
    end

    assign cd_q[u]           = cd_r;
    assign sd_q[u]           = sd_r;
    assign conv_start_out[u] = req_r;
    assign cfg_out[u]        = cfg_r;
    assign clk_en_out[u]     = !uctl_r[`SD_UC_STOP];
    assign irq_u[u]          = |(ist_r & imk_r);
  end

  // ----------------------------------------------------------------
  // Shared read data and interrupt outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_any = 32'h0;
    for (int i = 0; i < NU; i++)
      rd_any = rd_any | rd_u[i];
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= 32'h0;
    else
      rdata_out <= rd_in ? rd_any : 32'h0;
  end

  assign irq_out                 = |irq_u;
  assign unit0_conv_done_irq_out = cd_q[0];
  assign unit1_conv_done_irq_out = cd_q[1];
  assign unit0_scan_done_irq_out = sd_q[0];
  assign unit1_scan_done_irq_out = sd_q[1];
endmodule : sdadc_scan_ctrl
`default_nettype wire

// ===== verilog/sdadc_defines.svh
// Register map, field positions, reset values and count limits
`ifndef SDADC_DEFINES_SVH
`define SDADC_DEFINES_SVH
`define SD_NUM_CH       6
`define SD_NUM_UNIT     2
// Channel register fields (address bits [2:0], slot = channel)
`define SD_F_MODE       3'h0
`define SD_F_CTRL       3'h1
`define SD_F_OSR        3'h2
`define SD_F_GAIN       3'h3
`define SD_F_OFFS       3'h4
// Unit register fields (slot 7)
`define SD_UNIT_SLOT    3'h7
`define SD_F_UCTRL      3'h0
`define SD_F_START      3'h1
`define SD_F_STOP       3'h2
`define SD_F_RESULT     3'h3
`define SD_F_AVG        3'h4
`define SD_F_STAT       3'h5
`define SD_F_ISTAT      3'h6
`define SD_F_IMASK      3'h7
// Channel mode field positions
`define SD_MODE_EN      0
`define SD_MODE_AVG     1
`define SD_MODE_ASEL    3:2
`define SD_MODE_CNT     28:16
// Unit control field positions
`define SD_UC_MODE      1:0
`define SD_UC_HWTRIG    2
`define SD_UC_STOP      3
// Result word positions
`define SD_RES_OVF      24
`define SD_RES_ERR      25
`define SD_RES_CH       30:28
// Reset values, correction scale, count limit and averaging base
`define SD_GAIN_RST     16'h4000
`define SD_OSR_RST      16'h0100
`define SD_GAIN_FRAC    14
`define SD_MAX_CNT      13'h1F60
`define SD_AVG_MIN_LOG2 3
`endif

// ===== verilog/sdadc_pkg.sv
// Types shared by the sigma-delta scan controller
package sdadc_pkg;
  typedef enum logic [1:0] {
    SCAN_CONT   = 2'b00,
    SCAN_SINGLE = 2'b01,
    SCAN_ONE    = 2'b10
  } scan_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10
  } scan_state_e;
  typedef struct packed {
    logic [23:0] data;
    logic        ovf;
    logic        err;
  } sample_s;
  typedef struct packed {
    logic [2:0]  chan;
    logic [15:0] osr;
    logic [1:0]  disc_sel;
    logic        disc_en;
  } chan_cfg_s;
endpackage : sdadc_pkg

// ===== dv/sdadc_scan_ctrl_sva.sv
// Port checker for the scan controller
`timescale 1ns/1ps
`default_nettype none
module sdadc_scan_ctrl_chk
  import sdadc_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            rst_in,
  input wire logic [7:0]      addr_in,
  input wire logic [31:0]     wdata_in,
  input wire logic            wr_in,
  input wire logic            rd_in,
  input wire logic [31:0]     rdata_out,
  input wire logic [1:0]      conv_start_out,
  input wire chan_cfg_s [1:0] cfg_out,
  input wire logic [1:0]      clk_en_out,
  input wire logic [1:0]      sample_valid_in,
  input wire logic            unit0_conv_done_irq_out,
  input wire logic            unit1_conv_done_irq_out,
  input wire logic            unit0_scan_done_irq_out,
  input wire logic            irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_conv_done_0: assert property (unit0_conv_done_irq_out |-> $past(sample_valid_in[0]))
    else $error("unit 0 done pulse without result");
  a_conv_done_1: assert property (unit1_conv_done_irq_out |-> $past(sample_valid_in[1]))
    else $error("unit 1 done pulse without result");
  a_scan_with_conv: assert property (unit0_scan_done_irq_out |-> unit0_conv_done_irq_out)
    else $error("scan end without last result");
  a_stop_clk_en: assert property (wr_in && addr_in == 8'h70 |=> clk_en_out[0] == !$past(wdata_in[3]))
    else $error("clock enable does not follow stop bit");
  a_stop_quiet: assert property (!clk_en_out[0] |-> !conv_start_out[0])
    else $error("request while stopped");
  a_start_pulse: assert property (conv_start_out[0] |=> !conv_start_out[0])
    else $error("request longer than one cycle");
  a_cfg_channel: assert property (conv_start_out[1] |-> cfg_out[1].chan <= 3'h5)
    else $error("request for a channel above 5");
  a_cfg_held: assert property (conv_start_out[0] |=> $stable(cfg_out[0].chan))
    else $error("channel setup moved after request");
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
  c_scan_end: cover property (unit0_scan_done_irq_out);
  c_irq: cover property (irq_out);
  c_stop_release: cover property (!clk_en_out[0] ##1 clk_en_out[0]);
endmodule : sdadc_scan_ctrl_chk
bind sdadc_scan_ctrl sdadc_scan_ctrl_chk chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .conv_start_out(conv_start_out),
  .cfg_out(cfg_out), .clk_en_out(clk_en_out), .sample_valid_in(sample_valid_in),
  .unit0_conv_done_irq_out(unit0_conv_done_irq_out), .unit1_conv_done_irq_out(unit1_conv_done_irq_out),
  .unit0_scan_done_irq_out(unit0_scan_done_irq_out), .irq_out(irq_out));
`default_nettype wire

// ===== dv/sdadc_datapath_model.sv
// Behavioural modulator and filter datapath
`timescale 1ns/1ps
`default_nettype none
module sdadc_datapath_model
  import sdadc_pkg::*;
#(
  parameter int LAT = 8
)(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [1:0]      start_in,
  input  wire chan_cfg_s [1:0] cfg_in,
  input  wire logic            err_in,
  output logic      [1:0]      valid_out,
  output sample_s   [1:0]      sample_out
);
  logic [7:0] cnt_r [2];
  logic [2:0] ch_r  [2];
  // Count each request down, then answer with a channel-coded value
  always_ff @(posedge clk_in)
  begin
    for (int u = 0; u < 2; u++)
    begin
      valid_out[u] <= 1'b0;
      sample_out[u] <= ~sample_out[u];  // Idle lines toggle
      if (rst_in)
      begin
        cnt_r[u] <= 8'h00;
        sample_out[u] <= '0;
      end
      else if (start_in[u])
      begin
        cnt_r[u] <= 8'(LAT);
        ch_r[u] <= cfg_in[u].chan;
      end
      else if (cnt_r[u] != 8'h00)
      begin
        cnt_r[u] <= cnt_r[u] - 8'h01;
        valid_out[u] <= (cnt_r[u] == 8'h01);
        sample_out[u] <= {{5'h00, ch_r[u] + 3'h1, 16'h0000}, 1'b0, err_in};
      end
    end
  end
endmodule : sdadc_datapath_model
`default_nettype wire

// ===== dv/sdadc_scan_ctrl_test.sv
// Self-checking bench for the scan controller
`timescale 1ns/1ps
`default_nettype none
module sdadc_scan_ctrl_test
  import sdadc_pkg::*;
;
  logic            clk_in, rst_in, wr_in, rd_in, err, c0, c1, s0, s1, irq;
  logic [7:0]      addr;
  logic [31:0]     wdata, rdata;
  logic [1:0]      trig, start, clk_en, sval;
  chan_cfg_s [1:0] cfg;
  sample_s [1:0]   samp;
  int              errors, check_count;
  sdadc_scan_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata), .hw_trig_in(trig), .conv_start_out(start), .cfg_out(cfg),
    .clk_en_out(clk_en), .sample_valid_in(sval), .sample_in(samp), .unit0_conv_done_irq_out(c0),
    .unit1_conv_done_irq_out(c1), .unit0_scan_done_irq_out(s0), .unit1_scan_done_irq_out(s1), .irq_out(irq));
  sdadc_datapath_model model (.clk_in(clk_in), .rst_in(rst_in), .start_in(start), .cfg_in(cfg),
    .err_in(err), .valid_out(sval), .sample_out(samp));
  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic reset_dut;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : reset_dut
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  // Poll a unit's done pulse for at most 200 cycles
  task automatic wait_conv(input int u, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++)
    begin
      @(posedge clk_in);
      #1 ok = u ? c1 : c0;
    end
  endtask : wait_conv
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_scan;
    logic ok;
    int ch[3] = '{1, 3, 4};
    reset_dut;
    rd(8'h03, 32'h4000);
    rd(8'h02, 32'h0100);
    rd(8'h60, 32'h0);
    foreach (ch[i]) wr(8'(ch[i] << 4), 32'h1);
    wr(8'h77, 32'h3);
    wr(8'h70, 32'h1);
    wr(8'h71, 32'h0);
    foreach (ch[i])
    begin
      wait_conv(0, ok);
      chk({s0, ok}, {i == 2, 1'b1});
      rd(8'h73, (32'(ch[i]) << 28) | (32'(ch[i] + 1) << 16));
    end
    chk(irq, 1'b1);
    rd(8'h76, 32'h3);
    #1 chk(irq, 1'b0);
    wait_conv(0, ok);
    chk(ok, 1'b0);
  endtask : test_scan
  task automatic test_corr;
    logic ok;
    reset_dut;
    wr(8'h21, 32'h7);
    wr(8'h22, 32'h0200);
    wr(8'h23, 32'h8000);
    wr(8'h24, 32'h10000);
    wr(8'h20, 32'h1);
    wr(8'h70, 32'h2);
    err <= 1'b1;
    wr(8'h71, 32'h0);
    for (int n = 0; n < 50 && !start[0]; n++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk({cfg[0].chan, cfg[0].disc_sel, cfg[0].disc_en}, 6'b010_11_1);
    chk(cfg[0].osr, 32'h0200);
    wait_conv(0, ok);
    chk({s0, ok}, 2'b01);
    rd(8'h73, 32'h2204_0000);
    wait_conv(0, ok);
    chk(ok, 1'b0);
    err <= 1'b0;
  endtask : test_corr
  task automatic test_avg;
    logic ok;
    int cnt = 0;
    reset_dut;
    wr(8'h80, 32'h0008_0003);
    wr(8'hF0, 32'h5);
    @(posedge clk_in);
    trig <= 2'b10;
    @(posedge clk_in);
    trig <= 2'b00;
    repeat (8)
    begin
      wait_conv(1, ok);
      cnt += ok;
    end
    chk({s1, 8'(cnt)}, {1'b1, 8'h08});
    rd(8'hF4, 32'h10000);
    rd(8'hF3, 32'h10000);
  endtask : test_avg
  task automatic test_stop;
    logic ok;
    reset_dut;
    wr(8'h50, 32'h1);
    wr(8'h70, 32'h0);
    wr(8'h71, 32'h0);
    wait_conv(0, ok);
    wait_conv(0, ok);
    chk(ok, 1'b1);
    rd(8'h73, 32'h5006_0000);
    wr(8'h72, 32'h0);
    wait_conv(0, ok);
    chk(ok, 1'b0);
    wr(8'h70, 32'h8);
    #1 chk(clk_en, 2'b10);
    wr(8'h71, 32'h0);
    wait_conv(0, ok);
    chk(ok, 1'b0);
    wr(8'h70, 32'h0);
    #1 chk(clk_en, 2'b11);
  endtask : test_stop
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    {rst_in, wr_in, rd_in, err, addr, wdata, trig} = '0;
    test_scan;
    test_corr;
    test_avg;
    test_stop;
    complete_run;
  end
  // Watchdog cuts a hang short
  initial
  begin
    #500000;
    errors++;
    complete_run;
  end
endmodule : sdadc_scan_ctrl_test
`default_nettype wire
